//--- lcdcd_regs.svh
// Notes on behaviour
// R1: contrast range 0..127, resets to 63
// R2: higher contrast raises drive voltage, 63 midpoint
// R3: display off blanks segments; off after reset
// R4: display on is the only exit
// R5: column window takes start then end byte
// R6: host sends both bounds, start below end
// R7: column scan wraps to start, page steps
// R8: page window; page scan wraps, column steps
// R9: writes outside physical memory are dropped
// R10: column window reset 0..103 or 0..97
// R11: page window reset 0..83 or 0..66
// R12: memory write reloads starts, streams, steps
// R13: table load: 8 red, 8 green, 4 blue
// R14: 8-bit pixel expands to 12 bits
// R15: host loads whole table before 8-bit use
// R16: memory read reloads starts, steps per read
// R17: partial area start and end lines
// R18: scroll areas top, scroll, bottom counts
// R19: top fixed area follows common scan bit
// R20: test codes 34 and 35 do nothing
// R21: access control takes exactly one byte
// R22: access control bit layout
// R23: 8-bit pixels go through the table
// R24: command when dc low, data when high
// R25: surplus parameter bytes are ignored
`ifndef LCDCD_REGS_SVH
`define LCDCD_REGS_SVH

// command codes
`define LCDCD_CMD_CONTRAST  8'h25
`define LCDCD_CMD_DISP_OFF  8'h28
`define LCDCD_CMD_DISP_ON   8'h29
`define LCDCD_CMD_COL_WIN   8'h2a
`define LCDCD_CMD_PAGE_WIN  8'h2b
`define LCDCD_CMD_MEM_WR    8'h2c
`define LCDCD_CMD_LUT_LOAD  8'h2d
`define LCDCD_CMD_MEM_RD    8'h2e
`define LCDCD_CMD_PARTIAL   8'h30
`define LCDCD_CMD_SCROLL    8'h33
`define LCDCD_CMD_TEST_A    8'h34
`define LCDCD_CMD_TEST_B    8'h35
`define LCDCD_CMD_ACCESS    8'h36

// reset values
`define LCDCD_RST_CONTRAST      7'h3f
`define LCDCD_END_COL_FULL      8'h67
`define LCDCD_END_COL_SPLIT     8'h61
`define LCDCD_END_PAGE_FULL     8'h53
`define LCDCD_END_PAGE_SPLIT    8'h42
`define LCDCD_RST_BOTTOM_FIXED  8'h53

// physical memory limits
`define LCDCD_PHYS_LAST_COL     8'h67
`define LCDCD_PHYS_LAST_PAGE    8'h53

// access control field positions
`define LCDCD_ACC_PAGE_REV  7
`define LCDCD_ACC_COL_REV   6
`define LCDCD_ACC_EXCHANGE  5
`define LCDCD_ACC_COM_REV   4
`define LCDCD_ACC_BGR       3
`define LCDCD_ACC_VERT_INV  0

// colour table layout
`define LCDCD_LUT_GREEN_BASE  5'h08
`define LCDCD_LUT_BLUE_BASE   5'h10
`define LCDCD_LUT_LAST        5'h13

// strap settle count
`define LCDCD_STRAP_WAIT      2'h3

`endif

//--- lcdcd_pkg.sv
package lcdcd_pkg;

    typedef enum logic [9:0] {
        LCDCD_IDLE     = 10'b00_0000_0001,
        LCDCD_CONTRAST = 10'b00_0000_0010,
        LCDCD_COL_WIN  = 10'b00_0000_0100,
        LCDCD_PAGE_WIN = 10'b00_0000_1000,
        LCDCD_MEM_WR   = 10'b00_0001_0000,
        LCDCD_LUT_LOAD = 10'b00_0010_0000,
        LCDCD_MEM_RD   = 10'b00_0100_0000,
        LCDCD_PARTIAL  = 10'b00_1000_0000,
        LCDCD_SCROLL   = 10'b01_0000_0000,
        LCDCD_ACCESS   = 10'b10_0000_0000
    } lcdcd_state_t;

    typedef struct packed {
        logic       dc;
        logic [7:0] data;
    } lcdcd_host_byte_t;

    typedef struct packed {
        logic [7:0] start_column;
        logic [7:0] end_column;
        logic [7:0] start_page;
        logic [7:0] end_page;
    } lcdcd_win_t;

    typedef struct packed {
        logic [7:0] top_fixed_lines;
        logic [7:0] scroll_lines;
        logic [7:0] bottom_fixed_lines;
    } lcdcd_scroll_t;

    typedef struct packed {
        logic page_rev;
        logic col_rev;
        logic exchange;
        logic com_rev;
        logic bgr;
        logic vert_inv;
    } lcdcd_access_t;

endpackage

//--- lcdcd_decoder.sv
`timescale 1ns/1ns
`default_nettype none
`include "lcdcd_regs.svh"

module lcdcd_decoder
    import lcdcd_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // host byte stream
    input  wire logic             in_valid,
    input  wire lcdcd_host_byte_t in_byte,
    input  wire logic             rd_strobe,
    output var  logic [11:0]      rd_data,
    output var  logic             rd_valid,
    // pins and mode
    input  wire logic       memory_split_pin,
    input  wire logic       pixel_8bit,
    // display memory port
    output var  logic        mem_wr_en,
    output var  logic        mem_rd_en,
    output var  logic [7:0]  mem_page,
    output var  logic [7:0]  mem_column,
    output var  logic [11:0] mem_wr_data,
    input  wire logic [11:0] mem_rd_data,
    // settings to the panel
    output var  logic [6:0]    contrast_level,
    output var  logic          display_on,
    output var  lcdcd_win_t    window,
    output var  logic [7:0]    partial_start_line,
    output var  logic [7:0]    partial_end_line,
    output var  lcdcd_scroll_t scroll,
    output var  lcdcd_access_t access_dir,
    output var  logic          top_fixed_at_bottom
);

    lcdcd_state_t state;
    lcdcd_state_t next_state;
    logic [1:0]   param_idx;
    logic [7:0]   column;
    logic [7:0]   page;
    logic [7:0]   first_byte;
    logic         half_have;
    logic [4:0]   lut_idx;
    logic         lut_full;
    logic [3:0]   lut [0:19];
    logic         rd_pend;
    logic         split_s1;
    logic         split_s2;
    logic         split_s3;
    logic [1:0]   strap_cnt;
    logic         strap_done;

    // byte classification
    wire logic       cmd_in = in_valid & ~in_byte.dc; // R24
    wire logic       par_in = in_valid & in_byte.dc;  // R24
    wire logic [7:0] d      = in_byte.data;

    // command decode
    always_comb begin
        unique case (d)
            `LCDCD_CMD_CONTRAST: next_state = LCDCD_CONTRAST;
            `LCDCD_CMD_COL_WIN:  next_state = LCDCD_COL_WIN;
            `LCDCD_CMD_PAGE_WIN: next_state = LCDCD_PAGE_WIN;
            `LCDCD_CMD_MEM_WR:   next_state = LCDCD_MEM_WR;
            `LCDCD_CMD_LUT_LOAD: next_state = LCDCD_LUT_LOAD;
            `LCDCD_CMD_MEM_RD:   next_state = LCDCD_MEM_RD;
            `LCDCD_CMD_PARTIAL:  next_state = LCDCD_PARTIAL;
            `LCDCD_CMD_SCROLL:   next_state = LCDCD_SCROLL;
            `LCDCD_CMD_ACCESS:   next_state = LCDCD_ACCESS; // R21
            default:             next_state = LCDCD_IDLE; // R20
        endcase
    end

    // parameter bytes accepted per state
    wire logic p_contrast = par_in & (state == LCDCD_CONTRAST);
    wire logic p_col      = par_in & (state == LCDCD_COL_WIN);
    wire logic p_page     = par_in & (state == LCDCD_PAGE_WIN);
    wire logic p_partial  = par_in & (state == LCDCD_PARTIAL);
    wire logic p_scroll   = par_in & (state == LCDCD_SCROLL);
    wire logic p_access   = par_in & (state == LCDCD_ACCESS);
    wire logic p_memwr    = par_in & (state == LCDCD_MEM_WR);
    wire logic p_lut      = par_in & (state == LCDCD_LUT_LOAD) & ~lut_full;
    wire logic rd_take    = rd_strobe & (state == LCDCD_MEM_RD);

    // last expected parameter returns decoder to idle
    wire logic last_par = p_contrast | p_access
                        | ((p_col | p_page | p_partial) & param_idx[0])
                        | (p_scroll & param_idx[1]); // R25

    // state and parameter index
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state     <= LCDCD_IDLE;
            param_idx <= 2'h0;
        end else if (cmd_in) begin
            state     <= next_state;
            param_idx <= 2'h0;
        end else if (last_par) begin
            state     <= LCDCD_IDLE; // R25
            param_idx <= 2'h0;
        end else if (par_in) begin
            param_idx <= param_idx + 2'h1;
        end
    end

    // strap input synchroniser and settle counter
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            split_s1   <= 1'b0;
            split_s2   <= 1'b0;
            split_s3   <= 1'b0;
            strap_cnt  <= 2'h0;
            strap_done <= 1'b0;
        end else begin
            split_s1 <= memory_split_pin;
            split_s2 <= split_s1;
            split_s3 <= split_s2;
            if (!strap_done) begin
                strap_cnt  <= strap_cnt + 2'h1;
                strap_done <= (strap_cnt == `LCDCD_STRAP_WAIT)
                            & (split_s2 == split_s3);
            end
        end
    end

    // window end defaults chosen by the strap
    wire logic [7:0] def_end_col  = split_s3 ? `LCDCD_END_COL_SPLIT
                                             : `LCDCD_END_COL_FULL;
    wire logic [7:0] def_end_page = split_s3 ? `LCDCD_END_PAGE_SPLIT
                                             : `LCDCD_END_PAGE_FULL;

    // column and page windows
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            window.start_column <= 8'h00; // R10
            window.end_column   <= `LCDCD_END_COL_FULL;
            window.start_page   <= 8'h00; // R11
            window.end_page     <= `LCDCD_END_PAGE_FULL;
        end else begin
            if (!strap_done) begin
                window.end_column <= def_end_col; // R10
                window.end_page   <= def_end_page; // R11
            end
            if (p_col && !param_idx[0])
                window.start_column <= d; // R5
            if (p_col && param_idx[0])
                window.end_column <= d; // R5
            if (p_page && !param_idx[0])
                window.start_page <= d; // R8
            if (p_page && param_idx[0])
                window.end_page <= d; // R8
        end
    end

    // contrast and display on/off
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            contrast_level <= `LCDCD_RST_CONTRAST; // R1
            display_on     <= 1'b0; // R3
        end else begin
            if (p_contrast)
                contrast_level <= d[6:0]; // R1 R2
            if (cmd_in && d == `LCDCD_CMD_DISP_OFF)
                display_on <= 1'b0; // R3
            else if (cmd_in && d == `LCDCD_CMD_DISP_ON)
                display_on <= 1'b1; // R4
        end
    end

    // partial area and scroll areas
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            partial_start_line <= 8'h00; // R17
            partial_end_line   <= 8'h00;
            scroll.top_fixed_lines    <= 8'h00; // R18
            scroll.scroll_lines       <= 8'h00;
            scroll.bottom_fixed_lines <= `LCDCD_RST_BOTTOM_FIXED;
        end else begin
            if (p_partial && !param_idx[0])
                partial_start_line <= d; // R17
            if (p_partial && param_idx[0])
                partial_end_line <= d; // R17
            if (p_scroll && param_idx == 2'h0)
                scroll.top_fixed_lines <= d; // R18
            if (p_scroll && param_idx == 2'h1)
                scroll.scroll_lines <= d; // R18
            if (p_scroll && param_idx == 2'h2)
                scroll.bottom_fixed_lines <= d; // R18
        end
    end

    // access control byte
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            access_dir          <= '0;
            top_fixed_at_bottom <= 1'b0;
        end else if (p_access) begin
            access_dir.page_rev <= d[`LCDCD_ACC_PAGE_REV]; // R22
            access_dir.col_rev  <= d[`LCDCD_ACC_COL_REV];
            access_dir.exchange <= d[`LCDCD_ACC_EXCHANGE];
            access_dir.com_rev  <= d[`LCDCD_ACC_COM_REV];
            access_dir.bgr      <= d[`LCDCD_ACC_BGR];
            access_dir.vert_inv <= d[`LCDCD_ACC_VERT_INV];
            top_fixed_at_bottom <= d[`LCDCD_ACC_COM_REV]; // R19
        end
    end

    // colour table load index
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lut_idx  <= 5'h00;
            lut_full <= 1'b0;
        end else if (cmd_in) begin
            lut_idx  <= 5'h00;
            lut_full <= 1'b0;
        end else if (p_lut) begin
            lut_idx  <= lut_idx + 5'h01; // R13
            lut_full <= (lut_idx == `LCDCD_LUT_LAST); // R25
        end
    end

    // colour table entries, low nibble only, no reset contents
    genvar gi;
    generate
        for (gi = 0; gi < 20; gi++) begin : g_lut
            always_ff @(posedge clk) begin
                if (p_lut && lut_idx == 5'(gi))
                    lut[gi] <= d[3:0]; // R13 R15
            end
        end
    endgenerate

    // pixel expansion through the table
    wire logic [4:0] g_idx  = `LCDCD_LUT_GREEN_BASE + {2'b00, d[4:2]};
    wire logic [4:0] b_idx  = `LCDCD_LUT_BLUE_BASE + {3'b000, d[1:0]};
    wire logic [3:0] lut_r  = lut[{2'b00, d[7:5]}]; // R14
    wire logic [3:0] lut_g  = lut[g_idx];
    wire logic [3:0] lut_b  = lut[b_idx];
    wire logic [11:0] pix8  = {lut_r, lut_g, lut_b}; // R23
    wire logic [11:0] pix12 = {first_byte, d[3:0]};
    wire logic [11:0] pix   = pixel_8bit ? pix8 : pix12;
    wire logic [11:0] pix_o = access_dir.bgr
                            ? {pix[3:0], pix[7:4], pix[11:8]} : pix;

    // a pixel is complete on this data byte
    wire logic pix_done = p_memwr & (pixel_8bit | half_have); // R12

    // 12-bit pixels arrive as two bytes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            half_have  <= 1'b0;
            first_byte <= 8'h00;
        end else if (cmd_in || pixel_8bit) begin
            half_have <= 1'b0;
        end else if (p_memwr) begin
            half_have  <= ~half_have;
            first_byte <= d;
        end
    end

    // address stepping within the window
    wire logic col_end  = column == window.end_column;
    wire logic page_end = page == window.end_page;
    wire logic [7:0] col_inc  = col_end ? window.start_column
                                        : column + 8'h01;
    wire logic [7:0] page_inc = page_end ? window.start_page
                                         : page + 8'h01;
    wire logic [7:0] next_column = access_dir.exchange
                                 ? (page_end ? col_inc : column) // R8
                                 : col_inc; // R7
    wire logic [7:0] next_page   = access_dir.exchange
                                 ? page_inc // R8
                                 : (col_end ? page_inc : page); // R7
    wire logic step = pix_done | rd_take;
    wire logic load = cmd_in & (d == `LCDCD_CMD_MEM_WR
                              | d == `LCDCD_CMD_MEM_RD);

    // address counters
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            column <= 8'h00;
            page   <= 8'h00;
        end else if (load) begin
            column <= window.start_column; // R12 R16
            page   <= window.start_page;
        end else if (step) begin
            column <= next_column; // R7 R8
            page   <= next_page;
        end
    end

    // physical address with mirroring and range check
    wire logic in_range = (column <= `LCDCD_PHYS_LAST_COL)
                        & (page <= `LCDCD_PHYS_LAST_PAGE);
    wire logic [7:0] phys_col  = access_dir.col_rev
                               ? `LCDCD_PHYS_LAST_COL - column : column;
    wire logic [7:0] phys_page = access_dir.page_rev
                               ? `LCDCD_PHYS_LAST_PAGE - page : page;

    // memory port strobes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mem_wr_en   <= 1'b0;
            mem_rd_en   <= 1'b0;
            mem_page    <= 8'h00;
            mem_column  <= 8'h00;
            mem_wr_data <= 12'h000;
        end else begin
            mem_wr_en <= pix_done & in_range; // R9 R12
            mem_rd_en <= rd_take; // R16
            if (step) begin
                mem_page    <= phys_page;
                mem_column  <= phys_col;
                mem_wr_data <= pix_o;
            end
        end
    end

    // read data and rd_valid return two cycles after the memory strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_pend  <= 1'b0;
            rd_valid <= 1'b0;
            rd_data  <= 12'h000;
        end else begin
            rd_pend  <= mem_rd_en;
            rd_valid <= rd_pend;
            if (rd_pend)
                rd_data <= mem_rd_data; // R16 R9
        end
    end

endmodule
`default_nettype wire

//--- lcdcd_dispmem_model.sv
`timescale 1ns/1ns
`default_nettype none
module lcdcd_dispmem_model (
    // clock
    input  wire logic        clk,
    // access from the decoder
    input  wire logic        mem_wr_en,
    input  wire logic        mem_rd_en,
    input  wire logic [7:0]  mem_page,
    input  wire logic [7:0]  mem_column,
    input  wire logic [11:0] mem_wr_data,
    output var  logic [11:0] mem_rd_data
);
    // 84 pages by 104 columns
    logic [11:0] ram [0:83][0:103];
    initial mem_rd_data = 12'h5a5;
    // answer one cycle after a read, scramble otherwise
    always @(posedge clk) begin
        if (mem_wr_en)
            ram[mem_page][mem_column] <= mem_wr_data;
        if (mem_rd_en && mem_page < 8'h54 && mem_column < 8'h68)
            mem_rd_data <= ram[mem_page][mem_column];
        else
            mem_rd_data <= ~mem_rd_data;
    end
endmodule
`default_nettype wire

//--- lcdcd_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module lcdcd_monitor
    import lcdcd_pkg::*;
(
    // clock and reset
    input wire logic             clk,
    input wire logic             resetn,
    // host side
    input wire logic             in_valid,
    input wire lcdcd_host_byte_t in_byte,
    input wire logic             rd_valid,
    // memory side
    input wire logic             mem_wr_en,
    input wire logic             mem_rd_en,
    input wire logic [7:0]       mem_page,
    input wire logic [7:0]       mem_column,
    // settings
    input wire logic [6:0]       contrast_level,
    input wire logic             display_on,
    input wire lcdcd_access_t    access_dir,
    input wire logic             top_fixed_at_bottom
);
    // command decode helpers
    logic on_cmd;
    logic off_cmd;
    logic test_cmd;
    assign on_cmd = in_valid && !in_byte.dc && in_byte.data == 8'h29;
    assign off_cmd = in_valid && !in_byte.dc && in_byte.data == 8'h28;
    assign test_cmd = in_valid && !in_byte.dc && in_byte.data[7:1] == 7'h1a;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // command, idle cycle, first parameter
    sequence cmd_par_s(c);
        in_valid && !in_byte.dc && in_byte.data == c ##1 !in_valid
            ##1 in_valid && in_byte.dc;
    endsequence

    disp_on_a: assert property (on_cmd |=> display_on)
        else $error("display not on");
    disp_off_a: assert property (off_cmd |=> !display_on)
        else $error("display not off");
    disp_rise_a: assert property ($rose(display_on) |-> $past(on_cmd))
        else $error("display on without command");
    test_nop_a: assert property (test_cmd |=> $stable(display_on)
        && $stable(contrast_level) && $stable(access_dir))
        else $error("test code changed a setting");
    ctr_set_a: assert property (cmd_par_s(8'h25)
        |=> contrast_level == $past(in_byte.data[6:0]))
        else $error("contrast not loaded");
    acc_set_a: assert property (cmd_par_s(8'h36)
        |=> access_dir == {$past(in_byte.data[7:3]), $past(in_byte.data[0])})
        else $error("access direction not loaded");
    com_follow_a: assert property (cmd_par_s(8'h36) ##2 1'b1
        |-> top_fixed_at_bottom == $past(in_byte.data[4], 2))
        else $error("top fixed placement wrong");
    rd_lat_a: assert property (mem_rd_en |-> ##2 rd_valid)
        else $error("read answer late");
    wr_range_a: assert property (mem_wr_en
        |-> mem_column <= 8'h67 && mem_page <= 8'h53)
        else $error("write outside memory");
    wr_cause_a: assert property (mem_wr_en
        |-> $past(in_valid) && $past(in_byte.dc))
        else $error("write without data byte");
endmodule
bind lcdcd_decoder lcdcd_monitor u_mon (
    .clk(clk), .resetn(resetn), .in_valid(in_valid), .in_byte(in_byte),
    .rd_valid(rd_valid), .mem_wr_en(mem_wr_en), .mem_rd_en(mem_rd_en),
    .mem_page(mem_page), .mem_column(mem_column),
    .contrast_level(contrast_level), .display_on(display_on),
    .access_dir(access_dir), .top_fixed_at_bottom(top_fixed_at_bottom)
);
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import lcdcd_pkg::*;
    // stimulus
    logic             clk = 1'b0;
    logic             resetn = 1'b0;
    logic             in_valid = 1'b0;
    lcdcd_host_byte_t in_byte = '0;
    logic             rd_strobe = 1'b0;
    logic             split = 1'b0;
    logic             pix8 = 1'b0;
    // design outputs
    logic [11:0]      rd_data, mem_wr_data, mem_rd_data;
    logic             rd_valid, mem_wr_en, mem_rd_en, display_on, top_fix;
    logic [7:0]       mem_page, mem_column, part_s, part_e;
    logic [6:0]       contrast_level;
    lcdcd_win_t       window;
    lcdcd_scroll_t    scroll;
    lcdcd_access_t    access_dir;
    // bench model
    int               errors = 0;
    int               cmp_count = 0;
    int               seed = 38403;
    int               cycles = 0;
    logic [3:0]       lut [0:19];
    logic [11:0]      exp_ram [int];
    logic [27:0]      wq [$];
    logic [11:0]      rq [$];

    always #5 clk = ~clk;

    lcdcd_decoder DUT (
        .clk(clk), .resetn(resetn), .in_valid(in_valid), .in_byte(in_byte),
        .rd_strobe(rd_strobe), .rd_data(rd_data), .rd_valid(rd_valid),
        .memory_split_pin(split), .pixel_8bit(pix8),
        .mem_wr_en(mem_wr_en), .mem_rd_en(mem_rd_en), .mem_page(mem_page),
        .mem_column(mem_column), .mem_wr_data(mem_wr_data),
        .mem_rd_data(mem_rd_data), .contrast_level(contrast_level),
        .display_on(display_on), .window(window),
        .partial_start_line(part_s), .partial_end_line(part_e),
        .scroll(scroll), .access_dir(access_dir),
        .top_fixed_at_bottom(top_fix)
    );
    lcdcd_dispmem_model u_mem (
        .clk(clk), .mem_wr_en(mem_wr_en), .mem_rd_en(mem_rd_en),
        .mem_page(mem_page), .mem_column(mem_column),
        .mem_wr_data(mem_wr_data), .mem_rd_data(mem_rd_data)
    );

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one byte, then one idle cycle
    task automatic send(logic dc, logic [7:0] d);
        in_valid <= 1'b1;
        in_byte <= '{dc, d};
        @(posedge clk);
        in_valid <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_pix();
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        @(posedge clk);
    endtask
    task automatic do_reset(logic p);
        resetn <= 1'b0;
        split <= p;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    // window setup, then stream n pixels and predict every write
    task automatic wr_stream(int sc, int ec, int sp, int ep, int n,
                             logic [7:0] acc);
        int col, pg, k;
        logic [7:0] b1, b2, pp, pc;
        logic [11:0] d;
        col = sc;
        pg = sp;
        send(1'b0, 8'h36);
        send(1'b1, acc);
        send(1'b0, 8'h2a);
        send(1'b1, sc[7:0]);
        send(1'b1, ec[7:0]);
        send(1'b0, 8'h2b);
        send(1'b1, sp[7:0]);
        send(1'b1, ep[7:0]);
        check("window", window, {sc[7:0], ec[7:0], sp[7:0], ep[7:0]});
        send(1'b0, 8'h2c);
        for (k = 0; k < n; k++) begin
            b1 = 8'($random(seed));
            b2 = 8'($random(seed));
            if (pix8)
                d = {lut[b1[7:5]], lut[8 + b1[4:2]], lut[16 + b1[1:0]]};
            else
                d = {b1, b2[3:0]};
            // colour order swap and mirrored physical address
            if (acc[3])
                d = {d[3:0], d[7:4], d[11:8]};
            pp = acc[7] ? 8'(83 - pg) : pg[7:0];
            pc = acc[6] ? 8'(103 - col) : col[7:0];
            if (col <= 103 && pg <= 83) begin
                wq.push_back({pp, pc, d});
                exp_ram[pp * 256 + pc] = d;
            end
            send(1'b1, b1);
            if (!pix8)
                send(1'b1, b2);
            if (acc[5]) begin
                pg = (pg == ep) ? sp : pg + 1;
                if (pg == sp)
                    col = (col == ec) ? sc : col + 1;
            end else begin
                col = (col == ec) ? sc : col + 1;
                if (col == sc)
                    pg = (pg == ep) ? sp : pg + 1;
            end
        end
    endtask

    // compare memory traffic and read answers, cut hangs
    always @(posedge clk) begin
        if (resetn && mem_wr_en) begin
            if (wq.size() == 0)
                check("wr_extra", 1, 0);
            else
                check("wr", {mem_page, mem_column, mem_wr_data},
                      wq.pop_front());
        end
        if (resetn && rd_valid) begin
            if (rq.size() == 0)
                check("rd_extra", 1, 0);
            else
                check("rd_data", rd_data, rq.pop_front());
        end
        cycles++;
        if (cycles > 20000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        logic [7:0] v;
        int i;
        for (i = 1; i >= 0; i--) begin
            do_reset(i[0]);
            check("end_column", window.end_column, i ? 97 : 103);
            check("end_page", window.end_page, i ? 66 : 83);
        end
        check("contrast", contrast_level, 63);
        check("display_on", display_on, 0);
        check("starts", {window.start_column, window.start_page}, 0);
        check("partial", {part_s, part_e}, 0);
        check("scroll", scroll, 24'h000053);
        check("access", access_dir, 0);
        for (i = 0; i < 3; i++) begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : 8'($random(seed) & 127);
            send(1'b0, 8'h25);
            send(1'b1, v);
            send(1'b1, v ^ 8'h55);
            check("contrast", contrast_level, v);
        end
        send(1'b0, 8'h29);
        check("display_on", display_on, 1);
        send(1'b0, 8'h34);
        send(1'b0, 8'h35);
        check("display_on", display_on, 1);
        send(1'b0, 8'h28);
        send(1'b1, 8'h29);
        check("display_on", display_on, 0);
        v = 8'($random(seed)) & 8'h3f;
        send(1'b0, 8'h30);
        send(1'b1, v);
        send(1'b1, v + 8'h10);
        send(1'b0, 8'h33);
        send(1'b1, v);
        send(1'b1, 8'h2a);
        send(1'b1, v + 8'h01);
        send(1'b1, 8'hff);
        check("partial", {part_s, part_e}, {v, v + 8'h10});
        check("scroll", scroll, {v, 8'h2a, v + 8'h01});
        v = 8'($random(seed));
        send(1'b0, 8'h36);
        send(1'b1, v);
        send(1'b1, ~v);
        check("access", access_dir, {v[7:3], v[0]});
        check("top_fixed", top_fix, v[4]);
        send(1'b0, 8'h2d);
        for (i = 0; i < 20; i++) begin
            v = 8'($random(seed));
            lut[i] = v[3:0];
            send(1'b1, v);
        end
        pix8 <= 1'b1;
        wr_stream(2, 4, 5, 6, 8, 8'h00);
        rd_pix();
        send(1'b0, 8'h2e);
        for (i = 0; i < 6; i++) begin
            rq.push_back(exp_ram[(5 + i / 3) * 256 + 2 + i % 3]);
            rd_pix();
        end
        repeat (4) @(posedge clk);
        check("reads_left", rq.size(), 0);
        wr_stream(2, 4, 5, 6, 4, 8'h20);
        pix8 <= 1'b0;
        wr_stream(102, 105, 0, 1, 5, 8'hc8);
        repeat (4) @(posedge clk);
        check("writes_left", wq.size(), 0);
        summarize();
    end
endmodule
`default_nettype wire
